// File: hdl/port_power_consts.vh
`ifndef PORT_POWER_CONSTS_VH
`define PORT_POWER_CONSTS_VH

// core clock period in ns, 25 mhz
`define CLK_PERIOD_NS        40
// longest discharge pulse, in microseconds
`define DISCHARGE_MAX_US     50
`define DISCHARGE_CYCLES     ((`DISCHARGE_MAX_US * 1000) / `CLK_PERIOD_NS)
// vconn settle time before cc is judged, in microseconds
`define VCONN_SETTLE_US      10
`define VCONN_SETTLE_CYCLES  ((`VCONN_SETTLE_US * 1000) / `CLK_PERIOD_NS)
// overcurrent deglitch, in cycles
`define OC_FILTER_CYCLES     8
`define CNT_W                16
// reset levels; the pin stays driven low so an unconfigured port is never powered
`define PIN_OE_RESET         1'b1
`define PIN_LEVEL_RESET      1'b0
`define ALERT_IDLE_LEVEL     1'b1
`define FLAG_RESET           1'b0
`define CNT_RESET            16'h0000
`define OC_CNT_RESET         4'h0

`endif

// File: hdl/vconn_monitor.v
`include "port_power_consts.vh"

module vconn_monitor
(
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       enable,
    input  wire       cc_above_3v0,
    output reg        fault
);

    reg [`CNT_W-1:0] settle_r;

    // fault only judged after vconn has had time to rise
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            settle_r <= `CNT_RESET;
            fault    <= `FLAG_RESET;
        end
        else if (ce)
        begin
            if (!enable)
                settle_r <= 16'h0000;
            else if (settle_r != `VCONN_SETTLE_CYCLES)
                settle_r <= settle_r + 16'h0001;
            fault <= enable && (settle_r == `VCONN_SETTLE_CYCLES) && !cc_above_3v0;
        end
    end

endmodule

// File: hdl/oc_filter.v
`include "port_power_consts.vh"

module oc_filter
(
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       watch,
    input  wire       pin_n,
    output reg        oc
);

    reg [3:0] cnt_r;

    // low must hold for the filter length; short dips from plug-in are ignored
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_r <= `OC_CNT_RESET;
            oc    <= `FLAG_RESET;
        end
        else if (ce)
        begin
            if (!watch || pin_n)
                cnt_r <= 4'h0;
            else if (cnt_r != `OC_FILTER_CYCLES)
                cnt_r <= cnt_r + 4'h1;
            oc <= watch && !pin_n && (cnt_r == `OC_FILTER_CYCLES);
        end
    end

endmodule

// File: hdl/port_power_ctl.v
`include "port_power_consts.vh"

module port_power_ctl
(
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       companion_alert_in,
    output reg        companion_alert_event,
    input  wire       port1_vconn_req_a,
    input  wire       port1_vconn_req_b,
    output reg        port1_vconn_en_a,
    output reg        port1_vconn_en_b,
    input  wire       cc1_above_3v0,
    input  wire       cc2_above_3v0,
    input  wire       port1_vbus_off_req,
    input  wire       port1_vbus_safe0v,
    output reg        port1_vbus_discharge_en,
    input  wire       port6_cfg_enable,
    input  wire       port6_host_enable,
    input  wire       port6_power_ocs_in,
    output reg        port6_power_ocs_out,
    output reg        port6_power_ocs_oe,
    output reg        port6_pullup_en,
    output reg        port6_u2_power_on,
    output reg        port6_u3_power_on,
    output reg        port1_vconn_fault_sts,
    output reg        port6_oc_sts,
    input  wire       status_clear
);

    // discharge sequencer states
    localparam DIS_IDLE = 2'b00;
    localparam DIS_RUN  = 2'b01;
    localparam DIS_DONE = 2'b10;

    // discharge sequencer
    reg  [1:0]        dis_state_r;
    reg  [1:0]        dis_state_nxt;
    reg  [`CNT_W-1:0] dis_cnt_r;
    reg  [`CNT_W-1:0] dis_cnt_nxt;
    wire              dis_timeout;
    // edge and status helpers
    reg               alert_prev_r;
    wire              alert_fall;
    wire              port6_on;
    // monitor outputs
    wire              fault_a;
    wire              fault_b;
    wire              oc_det;

    // sticky update; the set term stands alone so an event beats a clear on the same edge
    function sticky_next;
        input ev;
        input held;
        input clr;
        begin
            sticky_next = ev || (held && !clr);
        end
    endfunction

    // run-state decode shared by the window counter and the discharge pin
    function in_run;
        input [1:0] state;
        begin
            in_run = (state == DIS_RUN);
        end
    endfunction

    // port is on only while both configuration and host allow it
    assign port6_on = port6_cfg_enable && port6_host_enable;

    // falling edge of the active-low companion request
    assign alert_fall = alert_prev_r && !companion_alert_in;

    // last cycle of the window; a rail that never reaches 0 v is let go here
    assign dis_timeout = (dis_cnt_r == (`DISCHARGE_CYCLES - 1));

    vconn_monitor u_mon_a
    (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .enable       (port1_vconn_en_a),
        .cc_above_3v0 (cc1_above_3v0),
        .fault        (fault_a)
    );

    vconn_monitor u_mon_b
    (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .enable       (port1_vconn_en_b),
        .cc_above_3v0 (cc2_above_3v0),
        .fault        (fault_b)
    );

    oc_filter u_oc
    (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .watch  (port6_on && port6_power_ocs_oe == 1'b0),
        .pin_n  (port6_power_ocs_in),
        .oc     (oc_det)
    );

    // discharge sequence: starts on a vbus-off request, ends at 0 v or timeout
    always @*
    begin
        dis_state_nxt = dis_state_r;
        case (dis_state_r)
            DIS_IDLE:
                if (port1_vbus_off_req && !port1_vbus_safe0v)
                    dis_state_nxt = DIS_RUN;
            DIS_RUN:
                if (port1_vbus_safe0v || dis_timeout)
                    dis_state_nxt = DIS_DONE;
            DIS_DONE:
                if (!port1_vbus_off_req)
                    dis_state_nxt = DIS_IDLE; // rearm only after request drops
            default:
                dis_state_nxt = DIS_IDLE;
        endcase
    end

    // window counter, cleared whenever the sequencer leaves the run state
    always @*
    begin
        if (in_run(dis_state_nxt))
            dis_cnt_nxt = dis_cnt_r + 16'h0001;
        else
            dis_cnt_nxt = `CNT_RESET;
    end

    // sequencer state register
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            dis_state_r <= DIS_IDLE;
        end
        else if (ce)
        begin
            dis_state_r <= dis_state_nxt;
        end
    end

    // discharge window counter
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            dis_cnt_r <= `CNT_RESET;
        end
        else if (ce)
        begin
            dis_cnt_r <= dis_cnt_nxt;
        end
    end

    // pin taken from the next state so it is registered yet not a cycle late
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port1_vbus_discharge_en <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port1_vbus_discharge_en <= in_run(dis_state_nxt);
        end
    end

    // vconn a follows its request one cycle late; off through reset
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port1_vconn_en_a <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port1_vconn_en_a <= port1_vconn_req_a;
        end
    end

    // vconn b follows its request one cycle late; off through reset
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port1_vconn_en_b <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port1_vconn_en_b <= port1_vconn_req_b;
        end
    end

    // pin driven while the port is off; driven through reset so the port stays unpowered
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port6_power_ocs_oe <= `PIN_OE_RESET;
        end
        else if (ce)
        begin
            port6_power_ocs_oe <= !port6_on;
        end
    end

    // driven level is always low; only the enable moves
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port6_power_ocs_out <= `PIN_LEVEL_RESET;
        end
        else if (ce)
        begin
            port6_power_ocs_out <= 1'b0;
        end
    end

    // pull-up applied only while the pin is released
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port6_pullup_en <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port6_pullup_en <= port6_on;
        end
    end

    // both halves of the port share one power decision
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port6_u2_power_on <= `FLAG_RESET;
            port6_u3_power_on <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port6_u2_power_on <= port6_on;
            port6_u3_power_on <= port6_on;
        end
    end

    // prev resets to the idle level so leaving reset is not seen as an edge
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            alert_prev_r <= `ALERT_IDLE_LEVEL;
        end
        else if (ce)
        begin
            alert_prev_r <= companion_alert_in;
        end
    end

    // companion request latched on its falling edge
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            companion_alert_event <= `FLAG_RESET;
        end
        else if (ce)
        begin
            companion_alert_event <= sticky_next(alert_fall, companion_alert_event, status_clear);
        end
    end

    // vconn fault kept after the fault itself goes away
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port1_vconn_fault_sts <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port1_vconn_fault_sts <= sticky_next(fault_a || fault_b, port1_vconn_fault_sts, status_clear);
        end
    end

    // overcurrent kept after the monitor lets go of the pin
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port6_oc_sts <= `FLAG_RESET;
        end
        else if (ce)
        begin
            port6_oc_sts <= sticky_next(oc_det, port6_oc_sts, status_clear);
        end
    end

endmodule

// File: bench/port_power_ctl_sva.sv
module port_power_ctl_sva
(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire companion_alert_in,
    input wire companion_alert_event,
    input wire port1_vconn_req_a,
    input wire port1_vconn_req_b,
    input wire port1_vconn_en_a,
    input wire port1_vconn_en_b,
    input wire cc1_above_3v0,
    input wire cc2_above_3v0,
    input wire port1_vbus_safe0v,
    input wire port1_vbus_discharge_en,
    input wire port6_cfg_enable,
    input wire port6_host_enable,
    input wire port6_power_ocs_in,
    input wire port6_power_ocs_out,
    input wire port6_power_ocs_oe,
    input wire port6_pullup_en,
    input wire port1_vconn_fault_sts,
    input wire port6_oc_sts,
    input wire status_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    wire on = port6_cfg_enable && port6_host_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // enables are registered copies of the requests
    AST_VCONN: assert property (ce |=> port1_vconn_en_a == $past(port1_vconn_req_a)
        && port1_vconn_en_b == $past(port1_vconn_req_b)) else $error("vconn enable");
    // a disabled port sinks its pin, an enabled one lets the pull-up power it
    AST_PIN_OFF: assert property (ce && !on |=> port6_power_ocs_oe && !port6_power_ocs_out)
        else $error("pin not low");
    AST_PIN_ON: assert property (ce && on |=> !port6_power_ocs_oe && port6_pullup_en)
        else $error("pin not released");
    // flags need their cause a few edges earlier
    AST_OC: assert property ($rose(port6_oc_sts) |-> !$past(port6_power_ocs_in, 3)) else $error("oc");
    AST_FAULT: assert property ($rose(port1_vconn_fault_sts) |->
        $past(port1_vconn_en_a, 2) && !$past(cc1_above_3v0, 2) ||
        $past(port1_vconn_en_b, 2) && !$past(cc2_above_3v0, 2)) else $error("fault");
    // status only drops on a clear
    AST_STICKY: assert property ($fell(port6_oc_sts) || $fell(port1_vconn_fault_sts) ||
        $fell(companion_alert_event) |-> $past(status_clear)) else $error("sticky");
    AST_DISCH: assert property (port1_vbus_discharge_en |-> !$past(port1_vbus_safe0v)) else $error("disch");
    AST_ALERT: assert property ($fell(companion_alert_in) |-> ##[1:2] companion_alert_event)
        else $error("alert");
endmodule

// File: bench/power_side_model.sv
module power_side_model
(
    input  wire  clk,
    input  wire  port1_vconn_en_a,
    input  wire  port1_vconn_en_b,
    input  wire  port1_vbus_discharge_en,
    input  wire  port6_power_ocs_oe,
    input  wire  port6_power_ocs_out,
    input  wire  cc_bad,
    input  wire  oc_now,
    input  wire  alert_req,
    input  wire  stuck,
    input  wire  vbus_up,
    output logic cc1_above_3v0,
    output logic cc2_above_3v0,
    output logic companion_alert_in,
    output logic port6_power_ocs_in,
    output logic port1_vbus_safe0v = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // cc only reaches 3v0 from an enabled, unshorted switch
    assign cc1_above_3v0 = port1_vconn_en_a && !cc_bad;
    assign cc2_above_3v0 = port1_vconn_en_b && !cc_bad;
    assign companion_alert_in = !alert_req;
    assign port6_power_ocs_in = port6_power_ocs_oe ? port6_power_ocs_out : !oc_now;
    // rail needs 20 cycles of discharge; a stuck rail never gets there
    always @(posedge clk)
    begin
        n <= port1_vbus_discharge_en ? n + 1 : 0;
        if (vbus_up)
            port1_vbus_safe0v <= 1'h0;
        else if (n == 20 && !stuck)
            port1_vbus_safe0v <= 1'h1;
    end
endmodule

// File: bench/tb_downstream_port_power_ctl.sv
module tb_downstream_port_power_ctl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, ce = 1, status_clear = 0, port1_vconn_req_a = 0, port1_vconn_req_b = 0;
    logic port1_vbus_off_req = 0, port6_cfg_enable = 0, port6_host_enable = 0;
    logic cc_bad = 0, oc_now = 0, alert_req = 0, stuck = 0, vbus_up = 0;
    wire companion_alert_in, companion_alert_event, port1_vconn_en_a, port1_vconn_en_b, cc1_above_3v0;
    wire cc2_above_3v0, port1_vbus_safe0v, port1_vbus_discharge_en, port6_power_ocs_in, port6_power_ocs_out;
    wire port6_power_ocs_oe, port6_pullup_en, port6_u2_power_on, port6_u3_power_on, port1_vconn_fault_sts;
    wire port6_oc_sts;
    int failures = 0, samples_checked = 0, seed = 32'h19079573, cnt;
    // dut and far-side model meet on the bench's nets by name
    port_power_ctl i_dut (.*);
    power_side_model i_far (.*);
    always #20 clk = ~clk;
    task t(input int n);
        repeat (n) @(negedge clk);
    endtask
    function logic on(input int i);
        return i == 3;
    endfunction
    task chk(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task clear;
        status_clear = 1;
        t(1);
        status_clear = 0;
        t(1);
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        t(8);
        resetn = 1;
        t(1);
        chk(port6_power_ocs_oe, 1, "reset oe");
        repeat (40)
        begin
            {port1_vconn_req_a, port1_vconn_req_b} = 2'($random(seed));
            t(1);
            chk(port1_vconn_en_a, port1_vconn_req_a, "en a");
            chk(port1_vconn_en_b, port1_vconn_req_b, "en b");
        end
        // freeze: requests move while ce is low, enables must hold
        {port1_vconn_req_a, port1_vconn_req_b} = 2'h0;
        t(1);
        ce = 0;
        {port1_vconn_req_a, port1_vconn_req_b} = 2'h3;
        t(3);
        chk(port1_vconn_en_a, 0, "frozen a");
        chk(port1_vconn_en_b, 0, "frozen b");
        ce = 1;
        t(1);
        chk(port1_vconn_en_a, 1, "thawed a");
        chk(port1_vconn_en_b, 1, "thawed b");
        $display("enable test done");
        for (int i = 0; i < 2; i++)
        begin
            {port1_vconn_req_a, port1_vconn_req_b} = i ? 2'h1 : 2'h2;
            t(300);
            chk(port1_vconn_fault_sts, 0, "false fault");
            cc_bad = 1;
            t(4);
            chk(port1_vconn_fault_sts, 1, "no fault");
            {port1_vconn_req_a, port1_vconn_req_b, cc_bad} = 3'h0;
            t(3);
            chk(port1_vconn_fault_sts, 1, "fault lost");
            clear;
            chk(port1_vconn_fault_sts, 0, "fault kept");
        end
        $display("vconn test done");
        for (int i = 0; i < 4; i++)
        begin
            {port6_cfg_enable, port6_host_enable} = 2'(i);
            t(2);
            chk(port6_power_ocs_oe, !on(i), "oe");
            chk(port6_power_ocs_out, 0, "pin level");
            chk(port6_pullup_en, on(i), "pull-up");
            chk(port6_u2_power_on & port6_u3_power_on, on(i), "parts");
            oc_now = 1;
            t(12);
            oc_now = 0;
            t(2);
            chk(port6_oc_sts, on(i), "oc");
            clear;
        end
        $display("port6 test done");
        port1_vbus_off_req = 1;
        t(1);
        chk(port1_vbus_discharge_en, 1, "no discharge");
        t(25);
        chk(port1_vbus_discharge_en, 0, "past 0v");
        vbus_up = 1;
        t(3);
        chk(port1_vbus_discharge_en, 0, "restarted");
        port1_vbus_off_req = 0;
        stuck = 1;
        t(2);
        vbus_up = 0;
        port1_vbus_off_req = 1;
        cnt = 0;
        repeat (1400)
        begin
            t(1);
            cnt += port1_vbus_discharge_en;
        end
        chk(cnt inside {[1249:1251]}, 1, "length");
        $display("discharge test done");
        // request falls on the same edge as a clear: the new event must win
        alert_req = 1;
        status_clear = 1;
        t(1);
        status_clear = 0;
        t(2);
        chk(companion_alert_event, 1, "alert");
        clear;
        chk(companion_alert_event, 0, "alert kept");
        $display("alert test done");
        end_of_test;
    end
    // cut a hang short well past the expected run
    initial
    begin
        t(5000);
        failures++;
        end_of_test;
    end
endmodule
bind port_power_ctl port_power_ctl_sva i_sva (.*);
